// File: wind_noise_gain_suppressor_tb.sv
// Purpose: self-checking bench for the wind suppressor
// Assumes: tick shortened to 8 cycles, attack and decay shifts set to 0
// Notes:   metric follows the raw value at once, so expectations are exact
`include "wnd_regs.svh"
`default_nettype none
module wind_noise_gain_suppressor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, rst, run, micValid, micReady;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [15:0] e;
    int          failCount, totalChecks, cycles, fullCycles, seed, d, s;
    wnd_pkg::wnd_mic_pair_t pair, micData;
    wnd_pkg::wnd_gains_t    gains;
    logic [7:0]  regAddr [5] = '{`WND_OFS_SENS, `WND_OFS_LOWTH,
                                 `WND_OFS_HIGHTH, `WND_OFS_RATE, `WND_OFS_FULL0};
    logic [31:0] regRst [5] = '{32'h64, 32'h12c, 32'h258, 32'h7eb8, 32'hccd};
    int          mv [5] = '{900, 450, 200, 600, 300};

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    wnd_suppressor #(.TICK_CYCLES(8)) dut (
        .core_clk(core_clk), .rst(rst),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hf), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .micValid(micValid),
        .micReady(micReady), .micData(micData), .gains(gains));

    wnd_mic_src mics (.core_clk(core_clk), .rst(rst), .run(run),
        .pair(pair), .micValid(micValid), .micReady(micReady),
        .micData(micData));

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ceiling well above the roughly 4700 cycles the sequence needs
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (micValid && !micReady)
            fullCycles <= fullCycles + 1;
        if (cycles == 20000)
        begin
            failCount++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp)
        begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            failCount++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        @(posedge core_clk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wvalid  <= 1'b1;
        s_axi_wdata   <= dat;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_awvalid || s_axi_wvalid);
        while (s_axi_bvalid !== 1'b1)
            @(posedge core_clk);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge core_clk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= a;
        s_axi_rready  <= 1'b1;
        do @(posedge core_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // long enough for a full fifo to drain and the gain to settle
    task automatic mic(input int a, input int b);
        pair <= {16'(a), 16'(b)};
        repeat (300) @(posedge core_clk);
    endtask

    // cap for thresholds 300 and 600
    function automatic logic [15:0] capf(input int m, input logic [15:0] f);
        int fr;
        if (m <= 300)
            return 16'h8000;
        if (m >= 600)
            return f;
        fr = (m - 300) * 256 / 300;
        return 16'h8000 - 16'(((32'h8000 - f) * fr) >> 8);
    endfunction

    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, run} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {pair, failCount, totalChecks, cycles, fullCycles} = 160'h0;
        rst = 1'b1;
        seed = $urandom(32);
        repeat (10) @(posedge core_clk);
        chk({16'h0, gains.outerGain}, 32'h8000);
        chk({16'h0, gains.innerGain}, 32'h8000);
        rst <= 1'b0;
        foreach (regAddr[i])
        begin
            rdr(regAddr[i]);
            chk(rd, regRst[i]);
        end
        rdr(8'h80);
        chk({30'h0, rs}, 32'h2);
        wr(`WND_OFS_ATTACK, 32'h0);
        wr(`WND_OFS_DECAY, 32'h0);
        wr(`WND_OFS_RATE, 32'h4000);
        wr(`WND_OFS_INNER, 32'h1234);
        wr(`WND_OFS_CTRL, 32'h1);
        run <= 1'b1;
        repeat (4)
        begin
            d = $urandom % 250;
            s = ($urandom % 4 + 1) * 50;
            wr(`WND_OFS_SENS, 32'(s));
            mic(1000, 1000 - d);
            rdr(`WND_OFS_METRIC);
            chk(rd, 32'(d * s / 100));
        end
        wr(`WND_OFS_SENS, 32'h64);
        foreach (mv[i])
        begin
            mic(1000, 1000 - mv[i]);
            e = capf(mv[i], 16'h0ccd);
            chk({16'h0, gains.outerGain}, {16'h0, e});
            chk({16'h0, gains.voiceGain}, {16'h0, e});
            chk({16'h0, gains.innerGain}, 32'h1234);
        end
        wr(`WND_OFS_FULL0 + 8'h04, 32'h0);
        wr(`WND_OFS_CTRL, 32'h3);
        mic(1000, 100);
        chk({16'h0, gains.outerGain}, 32'h0);
        wr(`WND_OFS_FULL0 + 8'h08, 32'h4000);
        wr(`WND_OFS_CTRL, 32'h5);
        mic(1000, 100);
        chk({16'h0, gains.voiceGain}, 32'h4000);
        wr(`WND_OFS_CTRL, 32'h1);
        mic(1000, 1000);
        wr(`WND_OFS_RATE, 32'h8000);
        mic(1000, 100);
        chk({16'h0, gains.outerGain}, 32'h8000);
        wr(`WND_OFS_CTRL, 32'h0);
        mic(1000, 300);
        rdr(`WND_OFS_METRIC);
        chk(rd, 32'd900);
        wr(`WND_OFS_METRIC, 32'h55);
        rdr(`WND_OFS_METRIC);
        chk(rd, 32'd900);
        wr(`WND_OFS_SEP, 32'h40);
        rdr(`WND_OFS_SEP);
        chk(rd, 32'h0c);
        wr(`WND_OFS_SEP, 32'h32);
        rdr(`WND_OFS_SEP);
        chk(rd, 32'h32);
        wr(8'h80, 32'h1);
        chk({30'h0, rs}, 32'h2);
        wr(`WND_OFS_CTRL, 32'h1);
        mic(5, -500);
        rdr(`WND_OFS_METRIC);
        chk(rd, 32'h0);
        chk({31'h0, fullCycles != 0}, 32'h1);
        report_and_stop();
    end
endmodule
`default_nettype wire

// File: wnd_mic_src.sv
// Purpose: outside microphone pair source feeding the suppressor
// Assumes: one pair offered per cycle while run is high
// Notes:   payload inverts while idle so stale data never looks fresh
`default_nettype none
module wnd_mic_src (
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    // command from the bench
    input  wire logic                   run,
    input  wire wnd_pkg::wnd_mic_pair_t pair,
    // stream towards the block
    output logic                        micValid,
    input  wire logic                   micReady,
    output wnd_pkg::wnd_mic_pair_t      micData
);
    timeunit 1ns;
    timeprecision 1ps;
    wnd_pkg::wnd_mic_pair_t held_q;
    // both outside microphones travel in every word
    always_ff @(posedge core_clk)
    begin
        if (rst)
            micValid <= 1'b0;
        else if (!micValid || micReady)
        begin
            micValid <= run;
            held_q   <= pair;
        end
    end
    assign micData = micValid ? held_q : ~held_q;
endmodule
`default_nettype wire

// File: wnd_pkg.sv
// Purpose: types shared by the wind suppressor
// Assumes: nothing beyond the register header
// Notes:   the sample pair carries both outside microphones together
`default_nettype none
package wnd_pkg;
    typedef struct packed {
        logic signed [15:0] outerA;
        logic signed [15:0] outerB;
    } wnd_mic_pair_t;
    typedef enum logic {WND_IDLE, WND_BUSY} wnd_eng_t;
    typedef struct packed {
        logic [15:0] outerGain;
        logic [15:0] voiceGain;
        logic [15:0] innerGain;
    } wnd_gains_t;
endpackage
`default_nettype wire

// File: wnd_regs.svh
// Purpose: register offsets, reset values and timing for the wind suppressor
// Assumes: 32-bit AXI4-Lite, one aligned word per register
// Notes:   gains are unsigned Q1.15, 16'h8000 is unity
`ifndef WND_REGS_SVH
`define WND_REGS_SVH
`define WND_OFS_CTRL    8'h00
`define WND_OFS_FLOOR   8'h04
`define WND_OFS_SENS    8'h08
`define WND_OFS_ATTACK  8'h0c
`define WND_OFS_DECAY   8'h10
`define WND_OFS_LOWTH   8'h14
`define WND_OFS_HIGHTH  8'h18
`define WND_OFS_RATE    8'h1c
`define WND_OFS_FULL0   8'h20
`define WND_OFS_INNER   8'h30
`define WND_OFS_METRIC  8'h34
`define WND_OFS_STATUS  8'h38
`define WND_OFS_SEP     8'h3c
`define WND_CTRL_EN     0
`define WND_CTRL_PRE_LO 1
`define WND_CTRL_PRE_HI 2
`define WND_CTRL_FS     3
`define WND_UNITY       16'h8000
`define WND_RST_FLOOR   16'h0010
`define WND_RST_SENS    16'h0064
`define WND_RST_ATTACK  4'h2
`define WND_RST_DECAY   4'h8
`define WND_RST_LOWTH   16'h012c
`define WND_RST_HIGHTH  16'h0258
`define WND_RST_RATE    16'h7eb8
`define WND_RST_FULL    16'h0ccd
`define WND_RST_SEP     8'h0c
`define WND_SEP_MIN_MM  8'h05
`define WND_SEP_MAX_MM  8'h32
`define WND_CLK_HZ      100000000
`define WND_UPD_HZ      12000
`define WND_PCT_FULL    100
`endif

// File: wnd_suppressor.sv
// Purpose: wind metric, suppression cap and gain ramp behind AXI4-Lite
// Assumes: microphone pairs arrive synchronous to core_clk
// Notes:   metric front end is a simple difference estimator
//
// Summary of operation
// (RULE_01) no suppression below low threshold, full suppression above high
// (RULE_02) applied fraction rises linearly between the two thresholds
// (RULE_03) only outer_path and voice gains ramp; inner_path gain untouched
// (RULE_04) metric computed continuously from the two outside microphones
// (RULE_05) full-suppression gain held per preset; active preset used
// (RULE_06) gain multiplied by rate factor at 12 kHz toward capped target
// (RULE_07) rate factor of one gives no attenuation step
// (RULE_08) attack setting only sets metric rise speed
// (RULE_09) decay setting only sets metric fall speed
// (RULE_10) outer_path energy below noise floor forces metric input to zero
// (RULE_11) metric scaled by sensitivity percentage
// (RULE_12) full gain zero mutes, one half attenuates six decibels
// (RULE_13) readable metric refreshed only while detection enabled
// (RULE_14) host enables leak_compensation support algorithm where needed
// (RULE_15) separation only for 96 or 192 kHz and 5 to 50 mm; code checks only the 5 to 50 mm range, not the rate
// (RULE_16) host enables third downsampler and connects both microphones
// (RULE_17) metric register is read-only; writes have no effect
`include "wnd_regs.svh"
`default_nettype none

module wnd_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    assign inReady  = (count_q != DEPTH[AW:0]);
    assign outValid = (count_q != '0);
    assign outData  = mem[rdPtr_q];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (pop)
            begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
            count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

    a_fifo_full: assert property (@(posedge core_clk) disable iff (rst)
        (count_q == DEPTH[AW:0]) |-> !inReady && wrPtr_q == rdPtr_q)
        else $error("fifo accepts while full");
endmodule

module wnd_suppressor #(
    parameter int FIFO_DEPTH  = 16,
    parameter int PROC_CYCLES = 4,
    parameter int TICK_CYCLES = `WND_CLK_HZ / `WND_UPD_HZ
) (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    // axi4-lite write
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    output logic      [1:0]           s_axi_bresp,
    // axi4-lite read
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    input  wire logic [7:0]           s_axi_araddr,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output logic      [31:0]          s_axi_rdata,
    output logic      [1:0]           s_axi_rresp,
    // outside microphone pairs
    input  wire logic                 micValid,
    output logic                      micReady,
    input  wire wnd_pkg::wnd_mic_pair_t micData,
    // path gains
    output wnd_pkg::wnd_gains_t       gains
);
    localparam int PW = $clog2(PROC_CYCLES + 1);
    localparam int TW = $clog2(TICK_CYCLES + 1);

    // registers
    logic        enable_q;
    logic [1:0]  preset_q;
    logic        fsHigh_q;
    logic [15:0] floor_q;
    logic [15:0] sens_q;
    logic [3:0]  attack_q;
    logic [3:0]  decay_q;
    logic [15:0] lowTh_q;
    logic [15:0] highTh_q;
    logic [15:0] rate_q;
    logic [15:0] fullGain_q [4];
    logic [15:0] innerGain_q;
    logic [7:0]  sep_q;
    logic [15:0] metric_q;
    logic [15:0] outerGain_q;

    // write channel
    logic        awHeld_q;
    logic [7:0]  awAddr_q;
    logic        wHeld_q;
    logic [31:0] wData_q;
    logic [3:0]  wStrb_q;
    logic        bValid_q;
    logic [1:0]  bResp_q;
    logic        doWrite;
    logic        wrHit;
    logic [7:0]  wrAddr;
    logic [15:0] wrHalf;

    assign s_axi_awready = !awHeld_q && !bValid_q;
    assign s_axi_wready  = !wHeld_q && !bValid_q;
    assign s_axi_bvalid  = bValid_q;
    assign s_axi_bresp   = bResp_q;
    assign doWrite       = awHeld_q && wHeld_q && !bValid_q;
    assign wrAddr        = awAddr_q;
    assign wrHalf        = wData_q[15:0];
    assign wrHit = (wrAddr[1:0] == 2'h0) && (wrAddr <= `WND_OFS_SEP);

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            bValid_q <= 1'b0;
            bResp_q  <= 2'h0;
            awAddr_q <= 8'h00;
            wData_q  <= 32'h0000_0000;
            wStrb_q  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (doWrite)
            begin
                awHeld_q <= 1'b0;
                wHeld_q  <= 1'b0;
                bValid_q <= 1'b1;
                bResp_q  <= wrHit ? 2'h0 : 2'h2;
            end
            else if (bValid_q && s_axi_bready)
            begin
                bValid_q <= 1'b0;
            end
        end
    end

    // register file; only the low two byte lanes carry data
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            enable_q    <= 1'b0;
            preset_q    <= 2'h0;
            fsHigh_q    <= 1'b0;
            floor_q     <= `WND_RST_FLOOR;
            sens_q      <= `WND_RST_SENS;
            attack_q    <= `WND_RST_ATTACK;
            decay_q     <= `WND_RST_DECAY;
            lowTh_q     <= `WND_RST_LOWTH;
            highTh_q    <= `WND_RST_HIGHTH;
            rate_q      <= `WND_RST_RATE;
            innerGain_q <= `WND_UNITY;
            sep_q       <= `WND_RST_SEP;
            for (int i = 0; i < 4; i++)
            begin
                fullGain_q[i] <= `WND_RST_FULL;
            end
        end
        else if (doWrite && wStrb_q[0])
        begin
            case (wrAddr)
                `WND_OFS_CTRL:
                begin
                    enable_q <= wData_q[`WND_CTRL_EN];
                    preset_q <= wData_q[`WND_CTRL_PRE_HI:`WND_CTRL_PRE_LO];
                    fsHigh_q <= wData_q[`WND_CTRL_FS];
                end
                `WND_OFS_FLOOR:  floor_q  <= wrHalf;
                `WND_OFS_SENS:   sens_q   <= wrHalf;
                `WND_OFS_ATTACK: attack_q <= wData_q[3:0]; // RULE_08
                `WND_OFS_DECAY:  decay_q  <= wData_q[3:0]; // RULE_09
                `WND_OFS_LOWTH:  lowTh_q  <= wrHalf;
                `WND_OFS_HIGHTH: highTh_q <= wrHalf;
                `WND_OFS_RATE:
                    rate_q <= (wrHalf > `WND_UNITY) ? `WND_UNITY : wrHalf;
                `WND_OFS_INNER:  innerGain_q <= wrHalf;
                `WND_OFS_SEP:
                    // out-of-range distances are dropped, old value kept
                    if (wData_q[7:0] >= `WND_SEP_MIN_MM
                        && wData_q[7:0] <= `WND_SEP_MAX_MM)
                    begin
                        sep_q <= wData_q[7:0]; // RULE_15
                    end
                default:
                    // preset gains sit at four consecutive words
                    if (wrAddr[7:4] == `WND_OFS_FULL0 >> 4)
                    begin
                        fullGain_q[wrAddr[3:2]] <= (wrHalf > `WND_UNITY)
                            ? `WND_UNITY : wrHalf; // RULE_05
                    end
            endcase
        end
    end

    // read channel; metric and status offsets are read-only
    logic        rValid_q;
    logic [31:0] rData_q;
    logic [1:0]  rResp_q;
    logic [31:0] rdWord;
    logic        rdHit;

    assign s_axi_arready = !rValid_q;
    assign s_axi_rvalid  = rValid_q;
    assign s_axi_rdata   = rData_q;
    assign s_axi_rresp   = rResp_q;

    always_comb
    begin
        rdHit  = (s_axi_araddr[1:0] == 2'h0)
                 && (s_axi_araddr <= `WND_OFS_SEP);
        rdWord = 32'h0000_0000;
        case (s_axi_araddr)
            `WND_OFS_CTRL:
                rdWord = {28'h0, fsHigh_q, preset_q, enable_q};
            `WND_OFS_FLOOR:  rdWord = {16'h0, floor_q};
            `WND_OFS_SENS:   rdWord = {16'h0, sens_q};
            `WND_OFS_ATTACK: rdWord = {28'h0, attack_q};
            `WND_OFS_DECAY:  rdWord = {28'h0, decay_q};
            `WND_OFS_LOWTH:  rdWord = {16'h0, lowTh_q};
            `WND_OFS_HIGHTH: rdWord = {16'h0, highTh_q};
            `WND_OFS_RATE:   rdWord = {16'h0, rate_q};
            `WND_OFS_INNER:  rdWord = {16'h0, innerGain_q};
            `WND_OFS_METRIC: rdWord = {16'h0, metric_q};
            `WND_OFS_STATUS: rdWord = {16'h0, outerGain_q};
            `WND_OFS_SEP:    rdWord = {24'h0, sep_q};
            default:
                if (s_axi_araddr[7:4] == `WND_OFS_FULL0 >> 4)
                begin
                    rdWord = {16'h0, fullGain_q[s_axi_araddr[3:2]]};
                end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rValid_q <= 1'b0;
            rData_q  <= 32'h0000_0000;
            rResp_q  <= 2'h0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rValid_q <= 1'b1;
            rData_q  <= rdHit ? rdWord : 32'h0000_0000;
            rResp_q  <= rdHit ? 2'h0 : 2'h2;
        end
        else if (rValid_q && s_axi_rready)
        begin
            rValid_q <= 1'b0;
        end
    end

    // sample buffer; the engine drains one pair per slot, so it can fill
    wnd_pkg::wnd_mic_pair_t fifoData;
    logic                   fifoValid;
    logic                   take;
    wnd_pkg::wnd_eng_t      eng_q;
    logic [PW-1:0]          busyCnt_q;

    assign take = fifoValid && (eng_q == wnd_pkg::WND_IDLE);

    wnd_fifo #(
        .WIDTH ($bits(wnd_pkg::wnd_mic_pair_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .rst      (rst),
        .inValid  (micValid),
        .inReady  (micReady),
        .inData   (micData),
        .outValid (fifoValid),
        .outReady (take),
        .outData  (fifoData)
    );

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            eng_q     <= wnd_pkg::WND_IDLE;
            busyCnt_q <= '0;
        end
        else
        begin
            case (eng_q)
                wnd_pkg::WND_IDLE:
                    if (take)
                    begin
                        eng_q     <= wnd_pkg::WND_BUSY;
                        busyCnt_q <= PW'(PROC_CYCLES - 1);
                    end
                wnd_pkg::WND_BUSY:
                    if (busyCnt_q == '0)
                    begin
                        eng_q <= wnd_pkg::WND_IDLE;
                    end
                    else
                    begin
                        busyCnt_q <= busyCnt_q - 1'b1;
                    end
                default: eng_q <= wnd_pkg::WND_IDLE;
            endcase
        end
    end

    // metric estimate: outside-mic difference, gated and scaled
    logic [16:0] energy;
    logic [16:0] diffMag;
    logic [33:0] scaledWide;
    logic [15:0] scaled_q;
    logic        scaledNew_q;

    always_comb
    begin
        energy  = fifoData.outerA[15] ? 17'(-fifoData.outerA)
                                      : 17'(fifoData.outerA);
        diffMag = 17'(fifoData.outerA) - 17'(fifoData.outerB);
        if (diffMag[16])
        begin
            diffMag = -diffMag;
        end
        // RULE_04 RULE_11
        scaledWide = 34'(diffMag) * 34'(sens_q) / 34'(`WND_PCT_FULL);
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            scaled_q    <= 16'h0000;
            scaledNew_q <= 1'b0;
        end
        else
        begin
            scaledNew_q <= take;
            if (take)
            begin
                if (energy < {1'b0, floor_q})
                begin
                    scaled_q <= 16'h0000; // RULE_10
                end
                else
                begin
                    scaled_q <= (scaledWide > 34'h0ffff) ? 16'hffff
                                : scaledWide[15:0];
                end
            end
        end
    end

    // attack/decay smoothing; frozen while detection is off
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            metric_q <= 16'h0000;
        end
        else if (scaledNew_q && enable_q) // RULE_13 RULE_17
        begin
            if (scaled_q > metric_q)
            begin
                metric_q <= metric_q + ((scaled_q - metric_q) >> attack_q);
            end
            else
            begin
                metric_q <= metric_q - ((metric_q - scaled_q) >> decay_q);
            end
        end
    end

    // suppression cap from metric and thresholds
    logic [8:0]  frac;
    logic [15:0] span;
    logic [15:0] activeFull;
    logic [24:0] depth;
    logic [15:0] cap;

    always_comb
    begin
        span       = highTh_q - lowTh_q;
        activeFull = fullGain_q[preset_q]; // RULE_05
        if (metric_q <= lowTh_q)
        begin
            frac = 9'h000; // RULE_01
        end
        else if (metric_q >= highTh_q || span == 16'h0000)
        begin
            frac = 9'h100; // RULE_01
        end
        else
        begin
            // RULE_02
            frac = 9'((24'(metric_q - lowTh_q) << 8) / 24'(span));
        end
        // RULE_12
        depth = 25'(`WND_UNITY - activeFull) * 25'(frac);
        cap   = enable_q ? (`WND_UNITY - depth[23:8]) : `WND_UNITY;
    end

    // 12 kHz update tick; a long count, so it is a parameter
    logic [TW-1:0] tickCnt_q;
    logic          tick;
    logic [31:0]   stepped;

    assign tick    = (tickCnt_q == '0);
    assign stepped = 32'(outerGain_q) * 32'(rate_q);

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            tickCnt_q <= TW'(TICK_CYCLES - 1);
        end
        else
        begin
            tickCnt_q <= tick ? TW'(TICK_CYCLES - 1) : tickCnt_q - 1'b1;
        end
    end

    // gain falls geometrically but never below cap; recovers at once
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            outerGain_q <= `WND_UNITY;
        end
        else if (tick) // RULE_06
        begin
            if (outerGain_q > cap)
            begin
                // RULE_07
                outerGain_q <= (stepped[30:15] < cap) ? cap : stepped[30:15];
            end
            else
            begin
                outerGain_q <= cap;
            end
        end
    end

    assign gains.outerGain = outerGain_q; // RULE_03
    assign gains.voiceGain = outerGain_q;
    assign gains.innerGain = innerGain_q; // RULE_03

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_tickDown;
        tick && outerGain_q > cap && rate_q < `WND_UNITY;
    endsequence

    a_below_low: assert property ( // RULE_01
        metric_q <= lowTh_q |-> cap == `WND_UNITY)
        else $error("suppression applied below low threshold");
    a_above_high: assert property (enable_q && metric_q >= highTh_q // RULE_01
        |-> cap == fullGain_q[preset_q])
        else $error("cap is not full suppression above high");
    a_inner_fixed: assert property ( // RULE_03
        !(doWrite && wrAddr == `WND_OFS_INNER) |=> $stable(gains.innerGain))
        else $error("inner gain moved");
    a_rate_unity: assert property (tick && rate_q == `WND_UNITY // RULE_07
        && outerGain_q > cap |=> $stable(outerGain_q))
        else $error("unity rate attenuated");
    a_gain_step: assert property (s_tickDown |=> outerGain_q // RULE_06
        < $past(outerGain_q) && outerGain_q >= $past(cap))
        else $error("gain step wrong");
    a_tick_only: assert property (!tick |=> $stable(outerGain_q)) // RULE_06
        else $error("gain moved between ticks");
    a_floor_zero: assert property (take && energy < {1'b0, floor_q} // RULE_10
        |=> scaled_q == 16'h0000)
        else $error("metric input not gated by floor");
    a_metric_frozen: assert property ( // RULE_13
        !enable_q |=> $stable(metric_q))
        else $error("metric refreshed while disabled");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid)
        else $error("write response dropped");
endmodule
`default_nettype wire
